// ---- core/prc_fault_latch.sv ----
module prc_fault_latch #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Conditions and clear command
    input wire logic [W-1:0] cause,
    input wire logic clear,
    // Latched indications
    output logic [W-1:0] latched
);
    logic [W-1:0] latched_reg;
    logic [W-1:0] latched_next;

    // A condition present during the clear stays set.
    always_comb begin
        if (clear) begin
            latched_next = cause;
        end else begin
            latched_next = latched_reg | cause;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            latched_reg <= '0;
        end else begin
            latched_reg <= latched_next;
        end
    end

    assign latched = latched_reg;
endmodule

// ---- core/prc_remote_ctrl.sv ----
// Function
// R1 - Switch 5 selects level or pulse start/stop
// R2 - Host holds momentary inputs for 200 ms
// R3 - Emergency output off until closed and reset
// R4 - Switch 2 selects always or running supervision
// R5 - Water check continues 15 minutes after stop
// R6 - Switch 7 picks dilution warning cause
// R7 - Switch 8 picks automatic or signalled booster
// R8 - Switch 4 stops pump on entering remote
// R9 - Switch 3 enables buzzer for faults
// R10 - Switch 1 selects 7 or 8 bit serial
// R11 - Switches captured once; remote and buzzer live
// R12 - Shipping default settings before capture
// R13 - Warnings and faults latch until reset
// R14 - Start refused while latched; report start failure
// R15 - Individual outputs active; collectives closed when healthy
// R16 - Run outputs and remote/local status output
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
module prc_remote_ctrl
    import prc_pkg::*;
#(
    parameter bit BOOSTER_AUTO_WHEN_ON = 1'b1,
    parameter logic [35:0] WATER_HOLD_CYCLES = PRC_WATER_HOLD_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Remote command pins
    input wire logic mainStartIn,
    input wire logic boosterStartIn,
    input wire logic faultClearIn,
    input wire logic mainStopIn,
    input wire logic boosterStopIn,
    // Panel selectors and switches
    input wire logic remoteSelIn,
    input wire logic buzzerUseIn,
    input wire logic [7:0] configSwIn,
    // Sensor condition pins
    input wire logic estopClosedIn,
    input wire logic inletVacuumOkIn,
    input wire logic dilutionValveOpenIn,
    input wire logic [7:0] tripSensorIn,
    input wire logic [7:0] warnSensorIn,
    // Status outputs
    output logic mainStageRun,
    output logic boosterStageRun,
    output logic remoteStatus,
    output logic estopOk,
    output logic anyShutdownFaultOk,
    output logic anyWarningOk,
    output logic [7:0] shutdownFault,
    output logic [7:0] warning,
    output logic dilutionFlowWarning,
    output logic buzzerOut,
    output logic serialEightBit
);

    function automatic logic hitReg(logic [7:0] adr, logic [7:0] ofs);
        hitReg = {adr[7:2], 2'b00} == ofs;
    endfunction

    // Pin synchronisation.
    logic [33:0] pinSync;
    logic [4:0] cmdSync;
    logic remoteSync;
    logic buzzerUseSync;
    logic estopClosedSync;
    logic vacOkSync;
    logic valveOpenSync;
    logic [7:0] warnSync;
    logic [7:0] tripSync;
    logic [7:0] swSync;

    prc_sync #(.W(34)) u_sync (
        .sys_clk(sys_clk),
        .asyncIn({configSwIn, tripSensorIn, warnSensorIn,
            dilutionValveOpenIn, inletVacuumOkIn, estopClosedIn,
            buzzerUseIn, remoteSelIn, boosterStopIn, mainStopIn,
            faultClearIn, boosterStartIn, mainStartIn}),
        .syncOut(pinSync)
    );

    assign cmdSync = pinSync[4:0];
    assign remoteSync = pinSync[5];
    assign buzzerUseSync = pinSync[6];
    assign estopClosedSync = pinSync[7];
    assign vacOkSync = pinSync[8];
    assign valveOpenSync = pinSync[9];
    assign warnSync = pinSync[17:10];
    assign tripSync = pinSync[25:18];
    assign swSync = pinSync[33:26];
    // State.
    logic [1:0] settleCnt_reg, settleCnt_next;
    logic settled_reg, settled_next;
    logic [7:0] config_reg, config_next;
    logic [4:0] cmdPrev_reg, cmdPrev_next;
    logic remotePrev_reg, remotePrev_next;
    logic mainRun_reg, mainRun_next;
    logic boosterSig_reg, boosterSig_next;
    logic boosterRun_reg, boosterRun_next;
    logic startFail_reg, startFail_next;
    logic estopLatched_reg, estopLatched_next, estopOk_reg, estopOk_next;
    logic mute_reg, mute_next;
    logic buzzer_reg, buzzer_next;
    logic remoteOut_reg, remoteOut_next;
    logic tripOk_reg, tripOk_next;
    logic warnOk_reg, warnOk_next;
    logic serial8_reg, serial8_next;
    logic [35:0] waterCnt_reg, waterCnt_next;
    logic ack_reg, ack_next;
    logic [31:0] dat_reg, dat_next;
    logic [4:0] rise, fall;
    logic remoteNow, enterRemote, pulseMode, boosterAuto;
    logic clearCmd, blocked, startReq, stopReq;
    logic waterWatch, n2Watch;
    logic panelWr, panelStart, panelStop, panelClear, panelMute;
    logic [7:0] tripCause, warnCause;
    logic [7:0] tripLatched, warnLatched;
    prc_fault_latch #(.W(8)) u_shutdown_fault (
        .sys_clk(sys_clk),
        .rst(rst),
        .cause(tripCause),
        .clear(clearCmd),
        .latched(tripLatched)
    ); // [R13]

    prc_fault_latch #(.W(8)) u_warn (
        .sys_clk(sys_clk),
        .rst(rst),
        .cause(warnCause),
        .clear(clearCmd),
        .latched(warnLatched)
    ); // [R13]

    // Register bus: writes act at the edge where the master sees ack.
    always_comb begin
        ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
        dat_next = 32'h0000_0000;
        if (ack_next && !wb_we_i) begin
            if (hitReg(wb_adr_i, PRC_STATUS_OFS)) begin
                dat_next[PRC_ST_MAIN_RUN] = mainRun_reg;
                dat_next[PRC_ST_BOOSTER_RUN] = boosterRun_reg;
                dat_next[PRC_ST_REMOTE] = remoteOut_reg;
                dat_next[PRC_ST_START_FAIL] = startFail_reg;
                dat_next[PRC_ST_ESTOP] = estopLatched_reg;
                dat_next[PRC_ST_BUZZER] = buzzer_reg;
                dat_next[PRC_ST_SETTLED] = settled_reg;
            end else if (hitReg(wb_adr_i, PRC_FAULT_OFS)) begin
                dat_next[15:0] = {warnLatched, tripLatched};
            end else if (hitReg(wb_adr_i, PRC_CONFIG_OFS)) begin
                dat_next[7:0] = config_reg;
            end
        end
        panelWr = ack_reg & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0]
            & hitReg(wb_adr_i, PRC_CTRL_OFS);
        panelStart = panelWr & wb_dat_i[PRC_CTRL_START];
        panelStop = panelWr & wb_dat_i[PRC_CTRL_STOP];
        panelClear = panelWr & wb_dat_i[PRC_CTRL_CLEAR];
        panelMute = panelWr & wb_dat_i[PRC_CTRL_MUTE];
    end

    // Stage control, supervision and indications.
    always_comb begin
        settleCnt_next = settleCnt_reg;
        settled_next = settled_reg;
        config_next = config_reg;
        if (!settled_reg) begin
            if (settleCnt_reg == PRC_SETTLE_CYC) begin
                config_next = swSync; // [R11]
                settled_next = 1'b1;
            end else begin
                settleCnt_next = settleCnt_reg + 2'h1;
            end
        end

        cmdPrev_next = settled_reg ? cmdSync : 5'h00;
        rise = cmdPrev_next & ~cmdPrev_reg;
        fall = ~cmdPrev_next & cmdPrev_reg;
        remoteNow = settled_reg & remoteSync; // [R11]
        remotePrev_next = remoteNow;
        enterRemote = remoteNow & ~remotePrev_reg;
        pulseMode = config_reg[PRC_SW_PULSE];
        boosterAuto = config_reg[PRC_SW_BOOSTER] == BOOSTER_AUTO_WHEN_ON; // [R7]
        clearCmd = panelClear | rise[2]; // [R13]
        blocked = (|tripLatched) | (|warnLatched) | estopLatched_reg;

        startReq = panelStart;
        stopReq = panelStop;
        if (remoteNow) begin
            if (pulseMode) begin
                startReq = rise[0]; // [R1]
                stopReq = rise[3]; // [R1]
            end else begin
                startReq = rise[0] | (enterRemote & cmdSync[0]); // [R1]
                stopReq = fall[0]; // [R1]
            end
        end
        if (enterRemote && config_reg[PRC_SW_REMOTE_STOP]) begin
            startReq = 1'b0; // [R8]
            stopReq = 1'b1; // [R8]
        end

        estopLatched_next = (settled_reg & ~estopClosedSync) // [R3]
            | (estopLatched_reg & ~(clearCmd & estopClosedSync));
        estopOk_next = ~estopLatched_next; // [R3]
        mainRun_next = mainRun_reg;
        if (stopReq || (|tripLatched) || estopLatched_next) begin
            mainRun_next = 1'b0;
        end else if (startReq && !blocked) begin
            mainRun_next = 1'b1; // [R14]
        end

        startFail_next = (startReq & blocked) // [R14]
            | (startFail_reg & ~clearCmd);
        boosterSig_next = boosterSig_reg;
        if (remoteNow) begin
            if (pulseMode) begin
                if (rise[4]) begin
                    boosterSig_next = 1'b0; // [R1]
                end else if (rise[1]) begin
                    boosterSig_next = 1'b1; // [R1]
                end
            end else if (enterRemote) begin
                boosterSig_next = cmdSync[1]; // [R1]
            end else if (rise[1] || fall[1]) begin
                boosterSig_next = rise[1]; // [R1]
            end
        end
        if (!mainRun_next) begin
            boosterSig_next = 1'b0;
        end
        if (boosterAuto || !remoteNow) begin
            boosterRun_next = mainRun_next & vacOkSync; // [R7]
        end else begin
            boosterRun_next = mainRun_next & boosterSig_next; // [R7]
        end

        waterCnt_next = waterCnt_reg;
        if (mainRun_reg) begin
            waterCnt_next = WATER_HOLD_CYCLES; // [R5]
        end else if (waterCnt_reg != 36'h0_0000_0000) begin
            waterCnt_next = waterCnt_reg - 36'h0_0000_0001; // [R5]
        end
        n2Watch = ~config_reg[PRC_SW_FLOW_OPONLY] | mainRun_reg; // [R4]
        waterWatch = n2Watch | (waterCnt_reg != 36'h0_0000_0000); // [R5]

        tripCause = settled_reg ? tripSync : 8'h00;
        warnCause = settled_reg ? warnSync : 8'h00;
        warnCause[PRC_WARN_WATER] = warnCause[PRC_WARN_WATER] & waterWatch;
        warnCause[PRC_WARN_SEAL] = warnCause[PRC_WARN_SEAL] & n2Watch;
        if (config_reg[PRC_SW_ZERO_DIL]) begin
            warnCause[PRC_WARN_DIL] = settled_reg & n2Watch
                & valveOpenSync; // [R6]
        end else begin
            warnCause[PRC_WARN_DIL] = warnCause[PRC_WARN_DIL]
                & n2Watch; // [R6]
        end

        mute_next = panelMute | (mute_reg & ~clearCmd);
        buzzer_next = config_reg[PRC_SW_BUZZER] & buzzerUseSync & ~mute_reg
            & ((|tripLatched) | (|warnLatched)); // [R9] [R11]

        remoteOut_next = remoteNow; // [R16]
        tripOk_next = ~|tripLatched; // [R15]
        warnOk_next = ~|warnLatched; // [R15]
        serial8_next = config_reg[PRC_SW_SERIAL8]; // [R10]
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            settleCnt_reg <= 2'h0;
            settled_reg <= 1'b0;
            config_reg <= PRC_SW_DEFAULT
                | (BOOSTER_AUTO_WHEN_ON ? 8'h80 : 8'h00); // [R12]
            cmdPrev_reg <= 5'h00;
            remotePrev_reg <= 1'b0;
            mainRun_reg <= 1'b0;
            boosterSig_reg <= 1'b0;
            boosterRun_reg <= 1'b0;
            startFail_reg <= 1'b0;
            estopLatched_reg <= 1'b0;
            estopOk_reg <= 1'b1;
            mute_reg <= 1'b0;
            buzzer_reg <= 1'b0;
            remoteOut_reg <= 1'b0;
            tripOk_reg <= 1'b1;
            warnOk_reg <= 1'b1;
            serial8_reg <= 1'b1;
            waterCnt_reg <= 36'h0_0000_0000;
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            settleCnt_reg <= settleCnt_next;
            settled_reg <= settled_next;
            config_reg <= config_next;
            cmdPrev_reg <= cmdPrev_next;
            remotePrev_reg <= remotePrev_next;
            mainRun_reg <= mainRun_next;
            boosterSig_reg <= boosterSig_next;
            boosterRun_reg <= boosterRun_next;
            startFail_reg <= startFail_next;
            estopLatched_reg <= estopLatched_next;
            estopOk_reg <= estopOk_next;
            mute_reg <= mute_next;
            buzzer_reg <= buzzer_next;
            remoteOut_reg <= remoteOut_next;
            tripOk_reg <= tripOk_next;
            warnOk_reg <= warnOk_next;
            serial8_reg <= serial8_next;
            waterCnt_reg <= waterCnt_next;
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign mainStageRun = mainRun_reg; // [R16]
    assign boosterStageRun = boosterRun_reg; // [R16]
    assign remoteStatus = remoteOut_reg;
    assign estopOk = estopOk_reg; // [R3]
    assign anyShutdownFaultOk = tripOk_reg;
    assign anyWarningOk = warnOk_reg;
    assign shutdownFault = tripLatched; // [R15]
    assign warning = warnLatched; // [R15]
    assign dilutionFlowWarning = warnLatched[PRC_WARN_DIL]; // [R6]
    assign buzzerOut = buzzer_reg;
    assign serialEightBit = serial8_reg;
endmodule

// ---- core/prc_sync.sv ----
module prc_sync #(
    parameter int W = 1
) (
    // Clock
    input wire logic sys_clk,
    // Pins in, synchronised out
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] stage1_reg;
    logic [W-1:0] stage2_reg;

    always_ff @(posedge sys_clk) begin
        stage1_reg <= asyncIn;
        stage2_reg <= stage1_reg;
    end

    assign syncOut = stage2_reg;
endmodule

// ---- dv/prc_host_model.sv ----
module prc_host_model #(
    parameter int PULSE_CYC = 4000000
) (
    // Clock
    input wire logic sys_clk,
    // Requests from the sequence
    input wire logic [4:0] pulseReq,
    input wire logic [1:0] levelReq,
    // Remote command pins
    output logic mainStartIn,
    output logic boosterStartIn,
    output logic faultClearIn,
    output logic mainStopIn,
    output logic boosterStopIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] held_reg = 5'h00;
    int holdCnt_reg = 0;
    // Each momentary command stays asserted for the whole hold time.
    always @(posedge sys_clk) begin
        if (pulseReq != 5'h00) begin
            held_reg <= pulseReq;
            holdCnt_reg <= PULSE_CYC;
        end else if (holdCnt_reg > 1) begin
            holdCnt_reg <= holdCnt_reg - 1;
        end else begin
            held_reg <= 5'h00;
        end
    end
    assign {boosterStopIn, mainStopIn, faultClearIn} = held_reg[4:2];
    assign mainStartIn = held_reg[0] | levelReq[0];
    assign boosterStartIn = held_reg[1] | levelReq[1];
endmodule

// ---- dv/prc_remote_ctrl_monitor.sv ----
module prc_remote_ctrl_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Wishbone slave side
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins
    input wire logic faultClearIn,
    input wire logic remoteSelIn,
    input wire logic buzzerUseIn,
    input wire logic mainStageRun,
    input wire logic remoteStatus,
    input wire logic estopOk,
    input wire logic anyShutdownFaultOk,
    input wire logic anyWarningOk,
    input wire logic [7:0] shutdownFault,
    input wire logic [7:0] warning,
    input wire logic dilutionFlowWarning,
    input wire logic buzzerOut,
    input wire logic serialEightBit
);
    logic [3:0] clrAge_reg;
    logic [3:0] clrAge_next;
    logic [3:0] rel_reg;
    logic [3:0] rel_next;
    logic clrHit;
    // Age of the last clear command, from the pin or a control write.
    always_comb begin
        clrHit = faultClearIn || (wb_ack_o && wb_we_i && wb_sel_i[0]
            && wb_adr_i[7:2] == 6'h00 && wb_dat_i[2]);
        clrAge_next = clrHit ? 4'h0 : clrAge_reg + {3'h0, clrAge_reg != 4'hF};
        rel_next = rel_reg + {3'h0, rel_reg != 4'hF};
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clrAge_reg <= 4'hF;
            rel_reg <= 4'h0;
        end else begin
            clrAge_reg <= clrAge_next;
            rel_reg <= rel_next;
        end
    end
    default clocking mcb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_ack_next: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_latch_hold: assert property (
        |($past(shutdownFault) & ~shutdownFault) ||
        |($past(warning) & ~warning) |-> clrAge_reg < 4'h8)
        else $error("latch dropped without clear");
    a_estop_hold: assert property (
        $rose(estopOk) |-> clrAge_reg < 4'h8)
        else $error("estop released without clear");
    a_shutdown_fault_sum: assert property (
        |shutdownFault |=> !anyShutdownFaultOk)
        else $error("fault collective stays closed");
    a_warn_sum: assert property (
        |warning |=> !anyWarningOk)
        else $error("warning collective stays closed");
    a_dil_copy: assert property (dilutionFlowWarning == warning[2])
        else $error("dilution warning pin missing");
    a_start_block: assert property (
        $rose(mainStageRun) |-> $past(shutdownFault | warning) == 8'h00)
        else $error("start while latched");
    a_buzz_quiet: assert property (
        (!buzzerUseIn)[*5] |-> !buzzerOut)
        else $error("buzzer sounds while unused");
    a_serial_init: assert property ($fell(rst) |-> serialEightBit)
        else $error("serial length default wrong");
    a_serial_keep: assert property (
        rel_reg == 4'hF |-> $stable(serialEightBit))
        else $error("captured setting changed");
    a_remote_live: assert property (
        (rel_reg == 4'hF && remoteSelIn)[*6] |-> remoteStatus)
        else $error("remote status not shown");
endmodule

bind prc_remote_ctrl prc_remote_ctrl_monitor mon (
    .sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .faultClearIn, .remoteSelIn,
    .buzzerUseIn, .mainStageRun, .remoteStatus, .estopOk,
    .anyShutdownFaultOk, .anyWarningOk, .shutdownFault, .warning,
    .dilutionFlowWarning, .buzzerOut, .serialEightBit
);

// ---- dv/prc_remote_ctrl_tb_top.sv ----
module prc_remote_ctrl_tb_top import prc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PW = 8;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic [4:0] pulseReq = 5'h00;
    logic [1:0] levelReq = 2'h0;
    logic mainStartIn, boosterStartIn, faultClearIn, mainStopIn;
    logic boosterStopIn, mainStageRun, boosterStageRun, remoteStatus;
    logic remoteSelIn = 1'b0, buzzerUseIn = 1'b1, estopClosedIn = 1'b1;
    logic inletVacuumOkIn = 1'b1, dilutionValveOpenIn = 1'b0;
    logic [7:0] configSwIn = 8'h85, tripSensorIn = 8'h00;
    logic [7:0] warnSensorIn = 8'h00, shutdownFault, warning, pat;
    logic estopOk, anyShutdownFaultOk, anyWarningOk, dilutionFlowWarning;
    logic buzzerOut, serialEightBit;
    logic [31:0] seed = 32'h000174D2;
    logic [31:0] expQ[$], mskQ[$];
    string nameQ[$];
    int n_errors = 0, n_compared = 0;
    always #25 sys_clk = ~sys_clk;
    prc_host_model #(.PULSE_CYC(PW)) host (
        .sys_clk, .pulseReq, .levelReq, .mainStartIn, .boosterStartIn,
        .faultClearIn, .mainStopIn, .boosterStopIn
    );
    prc_remote_ctrl #(
        .BOOSTER_AUTO_WHEN_ON(1'b1),
        .WATER_HOLD_CYCLES(36'h064)
    ) dut (
        .sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mainStartIn,
        .boosterStartIn, .faultClearIn, .mainStopIn, .boosterStopIn,
        .remoteSelIn, .buzzerUseIn, .configSwIn, .estopClosedIn,
        .inletVacuumOkIn, .dilutionValveOpenIn, .tripSensorIn,
        .warnSensorIn, .mainStageRun, .boosterStageRun, .remoteStatus,
        .estopOk, .anyShutdownFaultOk, .anyWarningOk, .shutdownFault,
        .warning, .dilutionFlowWarning, .buzzerOut, .serialEightBit
    );
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        int i;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'b11, w, a};
        {wb_dat_i, wb_sel_i} <= {d, s};
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        if (i >= 20) begin
            n_errors++;
            give_verdict();
        end else begin
            {wb_cyc_i, wb_stb_i} <= 2'b00;
            @(posedge sys_clk);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m, input string nm);
        expQ.push_back(e & m);
        mskQ.push_back(m);
        nameQ.push_back(nm);
        wb(1'b0, a, 32'h0, 4'hF);
    endtask
    task automatic ctl(input logic [31:0] d);
        wb(1'b1, PRC_CTRL_OFS, d, 4'hF);
        tick(4);
    endtask
    task automatic pulse(input int i);
        pulseReq <= 5'h01 << i;
        tick(1);
        pulseReq <= 5'h00;
        tick(PW + 12);
    endtask
    task automatic warn(input logic [7:0] p);
        warnSensorIn <= p;
        tick(8);
        warnSensorIn <= 8'h00;
        tick(4);
    endtask
    task automatic boot(input logic [7:0] sw);
        configSwIn <= sw;
        rst <= 1'b1;
        tick(4);
        rst <= 1'b0;
        tick(10);
    endtask
    // Every read answer is matched against the oldest expectation.
    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (expQ.size() == 0) begin
                chk("unexpected read", 32'h0, 32'h1);
            end else begin
                chk(nameQ.pop_front(), expQ.pop_front(),
                    wb_dat_o & mskQ.pop_front());
            end
        end
    end
    initial begin
        boot(8'h85);
        configSwIn <= 8'h00;
        rd(PRC_CONFIG_OFS, 32'h85, 32'hFF, "config");
        chk("serial8", 32'h1, serialEightBit);
        rd(8'h10, 32'h0, 32'hFFFFFFFF, "unmapped");
        wb(1'b1, PRC_STATUS_OFS, 32'hFFFFFFFF, 4'hF);
        wb(1'b1, PRC_CTRL_OFS, 32'h1, 4'hE);
        rd(PRC_STATUS_OFS, 32'h40, 32'h7F, "idle");
        ctl(32'h1);
        rd(PRC_STATUS_OFS, 32'h03, 32'h07, "local run");
        levelReq <= 2'h1;
        remoteSelIn <= 1'b1;
        tick(8);
        rd(PRC_STATUS_OFS, 32'h07, 32'h07, "remote");
        chk("remote pin", 32'h1, remoteStatus);
        pulse(3);
        rd(PRC_STATUS_OFS, 32'h07, 32'h07, "stop pin");
        levelReq <= 2'h0;
        tick(8);
        rd(PRC_STATUS_OFS, 32'h04, 32'h07, "level off");
        $display("test modes done");
        seed = nxt(seed);
        pat = seed[7:0] | 8'h01;
        tripSensorIn <= pat;
        tick(8);
        tripSensorIn <= 8'h00;
        tick(8);
        rd(PRC_FAULT_OFS, {24'h0, pat}, 32'hFF, "shutdown_fault");
        chk("shutdown_fault sum", 32'h0, anyShutdownFaultOk);
        chk("buzzer", 32'h1, buzzerOut);
        buzzerUseIn <= 1'b0;
        tick(8);
        chk("buzzer unused", 32'h0, buzzerOut);
        buzzerUseIn <= 1'b1;
        levelReq <= 2'h1;
        tick(8);
        rd(PRC_STATUS_OFS, 32'h08, 32'h09, "start fail");
        levelReq <= 2'h0;
        pulse(2);
        rd(PRC_FAULT_OFS, 32'h0, 32'hFFFF, "cleared");
        chk("shutdown_fault sum", 32'h1, anyShutdownFaultOk);
        estopClosedIn <= 1'b0;
        tick(8);
        estopClosedIn <= 1'b1;
        tick(8);
        chk("estop held", 32'h0, estopOk);
        pulse(2);
        chk("estop back", 32'h1, estopOk);
        repeat (3) begin
            seed = nxt(seed);
            pat = seed[7:0] | 8'h04;
            warn(pat);
            rd(PRC_FAULT_OFS, {16'h0, pat, 8'h0}, 32'hFFFF, "warn");
            chk("warn sum", 32'h0, anyWarningOk);
            chk("dilution", 32'h1, dilutionFlowWarning);
            pulse(2);
        end
        $display("test faults done");
        remoteSelIn <= 1'b0;
        boot(8'h5A);
        rd(PRC_CONFIG_OFS, 32'h5A, 32'hFF, "config b");
        chk("serial7", 32'h0, serialEightBit);
        ctl(32'h1);
        remoteSelIn <= 1'b1;
        tick(8);
        rd(PRC_STATUS_OFS, 32'h04, 32'h07, "auto stop");
        pulse(0);
        rd(PRC_STATUS_OFS, 32'h05, 32'h07, "pulse start");
        pulse(1);
        rd(PRC_STATUS_OFS, 32'h07, 32'h07, "booster pin");
        dilutionValveOpenIn <= 1'b1;
        tick(8);
        dilutionValveOpenIn <= 1'b0;
        tick(4);
        chk("zero dilution", 32'h1, dilutionFlowWarning);
        chk("no buzzer", 32'h0, buzzerOut);
        pulse(2);
        pulse(4);
        pulse(3);
        rd(PRC_STATUS_OFS, 32'h04, 32'h07, "pulse stop");
        warn(8'h03);
        rd(PRC_FAULT_OFS, 32'h100, 32'h300, "water hold");
        pulse(2);
        tick(120);
        warn(8'h01);
        rd(PRC_FAULT_OFS, 32'h0, 32'h300, "water idle");
        $display("test supervision done");
        give_verdict();
    end
endmodule

// ---- include/prc_pkg.sv ----
package prc_pkg;

    // Clock and the cooling-water supervision hold-over after a stop.
    localparam longint unsigned PRC_CLK_HZ = 20_000_000;
    localparam longint unsigned PRC_WATER_HOLD_MIN = 15;
    localparam logic [35:0] PRC_WATER_HOLD_CYC =
        36'(PRC_WATER_HOLD_MIN * 64'd60 * PRC_CLK_HZ);

    // Cycles after reset release before pin samples are trusted.
    localparam logic [1:0] PRC_SETTLE_CYC = 2'h3;

    // Register byte offsets.
    localparam logic [7:0] PRC_CTRL_OFS = 8'h00;
    localparam logic [7:0] PRC_STATUS_OFS = 8'h04;
    localparam logic [7:0] PRC_FAULT_OFS = 8'h08;
    localparam logic [7:0] PRC_CONFIG_OFS = 8'h0C;

    // Control register bits, write one to act.
    localparam int PRC_CTRL_START = 0;
    localparam int PRC_CTRL_STOP = 1;
    localparam int PRC_CTRL_CLEAR = 2;
    localparam int PRC_CTRL_MUTE = 3;

    // Status register bits.
    localparam int PRC_ST_MAIN_RUN = 0;
    localparam int PRC_ST_BOOSTER_RUN = 1;
    localparam int PRC_ST_REMOTE = 2;
    localparam int PRC_ST_START_FAIL = 3;
    localparam int PRC_ST_ESTOP = 4;
    localparam int PRC_ST_BUZZER = 5;
    localparam int PRC_ST_SETTLED = 6;

    // Configuration switch positions, switch n at bit n-1.
    localparam int PRC_SW_SERIAL8 = 0;
    localparam int PRC_SW_FLOW_OPONLY = 1;
    localparam int PRC_SW_BUZZER = 2;
    localparam int PRC_SW_REMOTE_STOP = 3;
    localparam int PRC_SW_PULSE = 4;
    localparam int PRC_SW_ZERO_DIL = 6;
    localparam int PRC_SW_BOOSTER = 7;

    // Shipping defaults except the booster switch, which follows polarity.
    localparam logic [7:0] PRC_SW_DEFAULT = 8'h05;

    // Warning positions with special supervision.
    localparam int PRC_WARN_WATER = 0;
    localparam int PRC_WARN_SEAL = 1;
    localparam int PRC_WARN_DIL = 2;

endpackage
